// ===== l1b_cache_ops.sv
`timescale 1ns/1ps
`include "l1b_params.svh"
// Contract
// - Flash-invalidate bits clear whole caches; icbi clears an instruction set.
// - Flush assist makes victim choice follow the pseudo-LRU tree only.
// - Data fills arrive as four 64-bit beats, critical double word first.
// - Requests, hits included, are taken only while idle; none are served while a fill is outstanding.
// - Critical double word is written, then forwarded the cycle after.
// - Read or intent-to-modify miss fills the whole line by one burst.
// - Instruction fill four beats, each forwarded the cycle after it is written; never snooped.
// - Snoop hit on a modified line pushes it to memory unless a single-beat condition holds.
// - Write-through, inhibited, disabled or locked accesses use single beats.
// - Burst indicator marks single versus four-beat burst of eight words.
// - Miss bursts start at the aligned missed double word; others at line base.
// - Critical-first bursts wrap within the line.
// - Non-inhibited data reads are issued as read-with-intent-to-modify.
// - Snooped cacheable reads flush; single-beat snooped reads are inhibited.
// - Only zero-block broadcasts always; others need broadcast enable.
// - Data cache control operations always reach the second-level cache; icbi does not.
// - Broadcast enable gates barriers; the barrier waits for idle queues.
// - icbi never broadcasts; only kill-block snoops from others are honoured.
// - Translation sync completes only after its input is negated.
// - Zero-block: exclusive/modified issues kill; invalid issues write-with-kill; ends modified.
// - Normally the lowest invalid way is chosen before pseudo-LRU.
module l1b_cache_ops
    import l1b_pkg::*;
(
    input  wire logic        pclk,          // Core clock
    input  wire logic        presetn,       // Asynchronous reset, active low
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB direction
    input  wire logic [11:0] paddr,         // APB address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire l1b_req_t    core_req,      // Core request with lookup result
    output logic             core_ready,    // Block can take a request
    output logic             core_fwd,      // Double word forwarded to requester
    output logic             core_done,     // Request finished
    input  wire logic        bus_grant,     // Bus took the address
    input  wire logic        beat_valid,    // Data beat arriving or accepted
    input  wire logic        queues_busy,   // Memory queues still active
    input  wire logic        tlb_sync_in,   // Translation sync pending input
    output l1b_busreq_t      bus_req,       // Bus request to the system
    output logic [1:0]       beat_dw,       // Double word index of current beat
    output logic             array_wr,      // Write beat into array
    output logic [2:0]       fill_way       // Way being filled
);

    // **********************************************************
    // Tag state storage
    // **********************************************************
    logic [7:0]     dvalid [0:127];
    logic [7:0]     ivalid [0:127];
    logic [6:0]     dplru  [0:127];
    logic [7:0]     dmod   [0:127];
    l1b_state_s_t   r;
    l1b_state_s_t   next_r;

    // Victim selection from valid bits and tree bits
    function automatic logic [2:0] pick_victim(input logic [7:0] v, input logic [6:0] b, input logic fa);
        logic [2:0] w;
        w = {b[0], b[0] ? b[2] : b[1], b[0] ? (b[2] ? b[6] : b[5]) : (b[1] ? b[4] : b[3])};
        if (!fa) begin
            for (int i = 7; i >= 0; i--) begin
                if (!v[i]) begin
                    w = 3'(i);
                end
            end
        end
        return w;
    endfunction

    // Tree update pointing away from the accessed way
    function automatic logic [6:0] touch(input logic [6:0] b, input logic [2:0] w);
        logic [6:0] n;
        n = b;
        n[0] = ~w[2];
        if (!w[2]) begin
            n[1] = ~w[1];
            if (!w[1]) n[3] = ~w[0]; else n[4] = ~w[0];
        end else begin
            n[2] = ~w[1];
            if (!w[1]) n[5] = ~w[0]; else n[6] = ~w[0];
        end
        return n;
    endfunction

    // Bus request builder
    function automatic l1b_busreq_t mk_bus(input l1b_bus_t k, input logic [31:0] a, input logic single,
                                           input logic l2);
        l1b_busreq_t q;
        q.valid     = (k != L1B_BUS_NONE);
        q.kind      = k;
        q.addr      = a;
        q.burst_n   = single;
        q.global_l2 = l2;
        return q;
    endfunction

    logic        apb_acc;
    logic        is_inh;
    logic        single;
    logic [6:0]  set_i;
    logic [2:0]  vict;
    logic        abe;

    assign apb_acc = psel && penable;
    assign is_inh  = core_req.attrs[2];
    assign set_i   = core_req.addr[11:5];
    assign abe     = r.cfg[`L1B_CFG_ABE_BIT];
    // Single-beat conditions
    assign single  = core_req.attrs[3] || is_inh || !r.cfg[`L1B_CFG_DCE_BIT]
                     || r.cfg[`L1B_CFG_LOCK_BIT];
    assign vict    = pick_victim(dvalid[set_i], dplru[set_i], r.cfg[`L1B_CFG_FA_BIT]);

    // **********************************************************
    // Next-state logic
    // **********************************************************
    always_comb begin
        next_r = r;
        next_r.pready  = 1'b0;
        next_r.pslverr = 1'b0;
        next_r.fwd     = 1'b0;
        next_r.done    = 1'b0;
        next_r.cfg[`L1B_CFG_DCACHE_FLASH_INVAL_BIT] = 1'b0;
        next_r.cfg[`L1B_CFG_ICACHE_FLASH_INVAL_BIT] = 1'b0;
        // APB slave, one-wait answer in the access phase
        if (apb_acc && !r.pready) begin
            next_r.pready = 1'b1;
            if (pwrite) begin
                unique case (paddr)
                    `L1B_OFF_CFG:     next_r.cfg = pwdata[5:0];
                    `L1B_OFF_SET_SEL: next_r.set_sel = pwdata[6:0];
                    default:          next_r.pslverr = (paddr != `L1B_OFF_STATUS);
                endcase
            end else begin
                unique case (paddr)
                    `L1B_OFF_CFG:     next_r.prdata = {26'h0, r.cfg};
                    `L1B_OFF_STATUS:  next_r.prdata = {24'h0, r.l2_bcast, 4'h0, 3'(r.st)};
                    `L1B_OFF_SET_SEL: next_r.prdata = {25'h0, r.set_sel};
                    `L1B_OFF_VALID:   next_r.prdata = {16'h0, ivalid[r.set_sel], dvalid[r.set_sel]};
                    `L1B_OFF_PSEUDO_LRU_TREE:    next_r.prdata = {25'h0, dplru[r.set_sel]};
                    `L1B_OFF_BUSOP:   next_r.prdata = {28'h0, r.last_busop};
                    `L1B_OFF_BUSADDR: next_r.prdata = r.bus.addr;
                    default: begin
                        next_r.prdata  = `L1B_ZERO32;
                        next_r.pslverr = 1'b1;
                    end
                endcase
            end
        end
        unique case (r.st)
            L1B_IDLE: begin
                if (core_req.valid) begin
                    next_r.l2_bcast = 1'b0;
                    next_r.st = L1B_ISSUE;
                    next_r.bus = mk_bus(L1B_BUS_NONE, core_req.addr, 1'b1, 1'b0);
                    next_r.crit = core_req.addr[4:3];
                    next_r.fill_icache = (core_req.op == L1B_OP_FETCH);
                    next_r.victim = vict;
                    unique case (core_req.op)
                        L1B_OP_LOAD, L1B_OP_STORE, L1B_OP_FETCH, L1B_OP_DCBT: begin
                            if (core_req.hit && core_req.op != L1B_OP_FETCH) begin
                                next_r.st = L1B_IDLE;
                                next_r.done = 1'b1;
                                next_r.fwd = 1'b1;
                            end else if (single && core_req.op != L1B_OP_FETCH) begin
                                next_r.bus = mk_bus(core_req.op == L1B_OP_STORE ? L1B_BUS_WRITE :
                                             (is_inh ? L1B_BUS_READ : L1B_BUS_RIM), core_req.addr,
                                             1'b1, 1'b0);
                            end else begin
                                // Miss burst at the aligned missed double word
                                next_r.bus = mk_bus(L1B_BUS_RIM, {core_req.addr[31:3], 3'h0}, 1'b0,
                                             1'b0);
                            end
                        end
                        L1B_OP_SYNC: begin
                            next_r.st = L1B_WAIT;
                            next_r.bus = mk_bus(abe ? L1B_BUS_SYNC : L1B_BUS_NONE, core_req.addr, 1'b1,
                                         1'b0);
                        end
                        L1B_OP_EIEIO:
                            next_r.bus = mk_bus(abe ? L1B_BUS_EIEIO : L1B_BUS_NONE, core_req.addr, 1'b1,
                                         1'b0);
                        L1B_OP_TLBSYNC: next_r.st = L1B_WAIT;
                        L1B_OP_ICBI: begin
                            next_r.st = L1B_IDLE;
                            next_r.done = 1'b1;
                        end
                        L1B_OP_DCBI, L1B_OP_DCBF, L1B_OP_DCBST: begin
                            next_r.l2_bcast = 1'b1;
                            if (core_req.hit && core_req.coh == L1B_MOD && core_req.op != L1B_OP_DCBI)
                                next_r.bus = mk_bus(L1B_BUS_WKILL, {core_req.addr[31:5], 5'h0}, 1'b0,
                                             1'b0);
                            else
                                next_r.bus = mk_bus(!abe ? L1B_BUS_NONE : (core_req.op == L1B_OP_DCBI ?
                                             L1B_BUS_KILL : (core_req.op == L1B_OP_DCBF ? L1B_BUS_FLUSH :
                                             L1B_BUS_CLEAN)), core_req.addr, 1'b1, 1'b0);
                        end
                        L1B_OP_DCBZ: begin
                            next_r.l2_bcast = 1'b1;
                            next_r.bus = mk_bus(core_req.hit ? L1B_BUS_KILL : L1B_BUS_WKILL,
                                         {core_req.addr[31:5], 5'h0}, 1'b1, 1'b0);
                        end
                        L1B_OP_SNOOP: begin
                            // Snooped kill or cacheable burst read hitting a modified line
                            if (core_req.hit && core_req.coh == L1B_MOD && !single)
                                next_r.bus = mk_bus(L1B_BUS_WRITE, {core_req.addr[31:5], 5'h0}, 1'b0,
                                             1'b0);
                        end
                        default: next_r.st = L1B_IDLE;
                    endcase
                end
            end
            L1B_ISSUE: begin
                if (!r.bus.valid) begin
                    next_r.st = L1B_IDLE;
                    next_r.done = 1'b1;
                end else if (bus_grant) begin
                    next_r.last_busop = r.bus.kind;
                    next_r.beat = 3'h0;
                    if (r.bus.burst_n) begin
                        next_r.st = L1B_IDLE;
                        next_r.done = 1'b1;
                        next_r.bus.valid = 1'b0;
                    end else begin
                        next_r.st = (r.bus.kind == L1B_BUS_RIM) ? L1B_FILL : L1B_PUSH;
                        next_r.bus.valid = 1'b0;
                    end
                end
            end
            L1B_FILL, L1B_PUSH: begin
                if (beat_valid) begin
                    // Critical word forwarded the cycle after it is written
                    next_r.fwd = (r.st == L1B_FILL) && (r.beat == 3'h0 || r.fill_icache);
                    next_r.beat = r.beat + 3'h1;
                    if (r.beat[1:0] == `L1B_BEAT_LAST) begin
                        next_r.st = L1B_IDLE;
                        next_r.done = 1'b1;
                    end
                end
            end
            L1B_WAIT: begin
                if (!queues_busy && !tlb_sync_in) begin
                    next_r.st = r.bus.valid ? L1B_ISSUE : L1B_IDLE;
                    next_r.done = !r.bus.valid;
                end
            end
            default: next_r.st = L1B_IDLE;
        endcase
        next_r.rdy = next_r.st == L1B_IDLE;
        next_r.wr  = next_r.st == L1B_FILL;
        next_r.dw  = next_r.crit + next_r.beat[1:0];
    end

    // **********************************************************
    // State register
    // **********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.cfg <= `L1B_CFG_RESET;
            r.st <= L1B_IDLE;
            r.rdy <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Tag-array valid, modified and tree bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int s = 0; s < `L1B_SETS; s++) begin
                dvalid[s] <= 8'h00;
                ivalid[s] <= 8'h00;
                dmod[s]   <= 8'h00;
                dplru[s]  <= `L1B_PSEUDO_LRU_TREE_RESET;
            end
        end else begin
            if (r.cfg[`L1B_CFG_DCACHE_FLASH_INVAL_BIT]) begin
                for (int s = 0; s < `L1B_SETS; s++) begin
                    dvalid[s] <= 8'h00;
                    dmod[s]   <= 8'h00;
                    dplru[s]  <= `L1B_PSEUDO_LRU_TREE_RESET;
                end
            end else if (core_req.valid && r.st == L1B_IDLE) begin
                if (core_req.hit && (core_req.op == L1B_OP_LOAD || core_req.op == L1B_OP_STORE))
                    dplru[set_i] <= touch(dplru[set_i], core_req.hit_way);
                if (core_req.hit && core_req.op == L1B_OP_STORE)
                    dmod[set_i][core_req.hit_way] <= 1'b1;
                if (core_req.op == L1B_OP_DCBZ) begin
                    dvalid[set_i][core_req.hit ? core_req.hit_way : vict] <= 1'b1;
                    dmod[set_i][core_req.hit ? core_req.hit_way : vict]   <= 1'b1;
                end
                if (core_req.hit && (core_req.op == L1B_OP_DCBI || core_req.op == L1B_OP_DCBF
                    || core_req.op == L1B_OP_SNOOP)) begin
                    dvalid[set_i][core_req.hit_way] <= 1'b0;
                    dmod[set_i][core_req.hit_way]   <= 1'b0;
                end
                if (core_req.hit && core_req.op == L1B_OP_DCBST)
                    dmod[set_i][core_req.hit_way] <= 1'b0;
            end else if (r.st == L1B_FILL && beat_valid && r.beat == 3'h0 && !r.fill_icache) begin
                dvalid[r.bus.addr[11:5]][r.victim] <= 1'b1;
                dplru[r.bus.addr[11:5]] <= touch(dplru[r.bus.addr[11:5]], r.victim);
            end
            if (r.cfg[`L1B_CFG_ICACHE_FLASH_INVAL_BIT]) begin
                for (int s = 0; s < `L1B_SETS; s++) begin
                    ivalid[s] <= 8'h00;
                end
            end else if (core_req.valid && r.st == L1B_IDLE && core_req.op == L1B_OP_ICBI) begin
                ivalid[set_i] <= 8'h00;
            end else if (r.st == L1B_FILL && beat_valid && r.beat == 3'h0 && r.fill_icache) begin
                ivalid[r.bus.addr[11:5]][r.victim] <= 1'b1;
            end
        end
    end

    // **********************************************************
    // Outputs
    // **********************************************************
    assign prdata     = r.prdata;
    assign pready     = r.pready;
    assign pslverr    = r.pslverr;
    assign core_ready = r.rdy;
    assign core_fwd   = r.fwd;
    assign core_done  = r.done;
    assign bus_req    = r.bus;
    assign beat_dw    = r.dw;
    assign array_wr   = r.wr;
    assign fill_way   = r.victim;

endmodule

// ===== l1b_params.svh
`ifndef L1B_PARAMS_SVH
`define L1B_PARAMS_SVH
// Register byte offsets
`define L1B_OFF_CFG       12'h000
`define L1B_OFF_STATUS    12'h004
`define L1B_OFF_SET_SEL   12'h008
`define L1B_OFF_VALID     12'h00c
`define L1B_OFF_PSEUDO_LRU_TREE      12'h010
`define L1B_OFF_BUSOP     12'h014
`define L1B_OFF_BUSADDR   12'h018
// Control field positions in the configuration register
`define L1B_CFG_DCACHE_FLASH_INVAL_BIT  0
`define L1B_CFG_ICACHE_FLASH_INVAL_BIT  1
`define L1B_CFG_FA_BIT    2
`define L1B_CFG_DCE_BIT   3
`define L1B_CFG_LOCK_BIT  4
`define L1B_CFG_ABE_BIT   5
`define L1B_CFG_RESET     6'h08
// Geometry
`define L1B_SETS          128
`define L1B_WAYS          8
`define L1B_BEATS         3'h4
`define L1B_BEAT_LAST     2'h3
`define L1B_PSEUDO_LRU_TREE_RESET    7'h00
`define L1B_ZERO32        32'h0000_0000
`endif

// ===== l1b_pkg.sv
package l1b_pkg;
    // Core-side request kinds
    typedef enum logic [3:0] {
        L1B_OP_LOAD, L1B_OP_STORE, L1B_OP_FETCH, L1B_OP_SYNC, L1B_OP_EIEIO,
        L1B_OP_TLBSYNC, L1B_OP_ICBI, L1B_OP_DCBI, L1B_OP_DCBF, L1B_OP_DCBST,
        L1B_OP_DCBZ, L1B_OP_DCBT, L1B_OP_SNOOP
    } l1b_op_t;

    // Bus transfer kinds issued by the block
    typedef enum logic [3:0] {
        L1B_BUS_NONE, L1B_BUS_RIM, L1B_BUS_READ, L1B_BUS_WRITE, L1B_BUS_WKILL,
        L1B_BUS_KILL, L1B_BUS_FLUSH, L1B_BUS_CLEAN, L1B_BUS_SYNC, L1B_BUS_EIEIO
    } l1b_bus_t;

    // Line coherency state
    typedef enum logic [1:0] {L1B_INV, L1B_EXC, L1B_MOD} l1b_coh_t;

    // Core request bundle
    typedef struct packed {
        logic          valid;
        l1b_op_t       op;
        logic [31:0]   addr;
        logic [3:0]    attrs;   // Write-through, inhibited, coherent, guarded
        logic          hit;     // Tag lookup result from the array
        logic [2:0]    hit_way;
        l1b_coh_t      coh;     // State of the hit line
    } l1b_req_t;

    // Bus request bundle
    typedef struct packed {
        logic          valid;
        l1b_bus_t      kind;
        logic [31:0]   addr;
        logic          burst_n;
        logic          global_l2;
    } l1b_busreq_t;

    typedef enum logic [2:0] {L1B_IDLE, L1B_ISSUE, L1B_FILL, L1B_PUSH, L1B_WAIT} l1b_state_t;

    // Whole module state
    typedef struct packed {
        l1b_state_t    st;
        logic [5:0]    cfg;
        logic          rdy;
        logic          wr;
        logic [1:0]    dw;
        logic [6:0]    set_sel;
        l1b_busreq_t   bus;
        logic [1:0]    crit;
        logic [2:0]    beat;
        logic          fill_icache;
        logic [2:0]    victim;
        logic          fwd;
        logic          done;
        logic          l2_bcast;
        logic [3:0]    last_busop;
        logic [31:0]   prdata;
        logic          pready;
        logic          pslverr;
    } l1b_state_s_t;
endpackage

// ===== l1b_checker.sv
`timescale 1ns/1ps
// ********
// Bus and fill checker
// ********
module l1b_checker
    import l1b_pkg::*;
(
    input wire logic        pclk,       // Clock
    input wire logic        presetn,    // Reset
    input wire logic        psel,       // Select
    input wire logic        penable,    // Enable
    input wire logic        pready,     // Ready
    input wire l1b_busreq_t bus_req,    // Bus request
    input wire logic        bus_grant,  // Grant
    input wire logic        beat_valid, // Beat
    input wire logic [1:0]  beat_dw,    // Beat index
    input wire logic        array_wr,   // Fill active
    input wire logic        core_fwd    // Forward
);
    logic [2:0] bc;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence beat_s;
        array_wr && beat_valid;
    endsequence
    // Beats taken in the current fill
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) bc <= 3'h0;
        else bc <= array_wr ? bc + {2'h0, beat_valid} : 3'h0;
    end
    apb_ready_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
    req_hold_a: assert property (bus_req.valid && !bus_grant |=> bus_req.valid && $stable(bus_req))
        else $error("bus request not held");
    rim_burst_a: assert property (
        bus_req.valid && bus_req.kind == L1B_BUS_RIM |-> bus_req.burst_n || bus_req.addr[2:0] == 3'h0)
        else $error("fill request malformed");
    read_single_a: assert property (
        bus_req.valid && bus_req.kind == L1B_BUS_READ |-> bus_req.burst_n) else $error("plain read burst");
    wkill_base_a: assert property (
        bus_req.valid && bus_req.kind == L1B_BUS_WKILL && !bus_req.burst_n |-> bus_req.addr[4:0] == 5'h0)
        else $error("push not at line base");
    beat_wrap_a: assert property (beat_s ##1 array_wr |-> beat_dw == $past(beat_dw) + 2'h1)
        else $error("beat order wrong");
    fill_len_a: assert property (bc <= 3'h4) else $error("fill over four beats");
    fwd_write_a: assert property (beat_s ##0 bc == 3'h0 |=> core_fwd) else $error("first beat not forwarded");
endmodule
bind l1b_cache_ops l1b_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .bus_req(bus_req), .bus_grant(bus_grant), .beat_valid(beat_valid),
    .beat_dw(beat_dw), .array_wr(array_wr), .core_fwd(core_fwd));

// ===== l1b_bus_model.sv
`timescale 1ns/1ps
// ********
// System bus and memory model
// ********
module l1b_bus_model
    import l1b_pkg::*;
(
    input wire logic        pclk,      // Clock
    input wire logic        presetn,   // Reset
    input wire logic        slow,      // Answer every other cycle
    input wire l1b_busreq_t bus_req,   // Request
    output logic            bus_grant, // Grant
    output logic            beat_valid // Beat
);
    logic [2:0] left;
    logic       tog;
    logic       go;
    assign go = !slow || tog;
    // Grant one request, then stream its data beats
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {bus_grant, beat_valid, left, tog} <= '0;
        end else begin
            tog <= ~tog;
            bus_grant <= bus_req.valid && !bus_grant && left == 3'h0 && go;
            beat_valid <= left != 3'h0 && go;
            if (bus_req.valid && !bus_grant && left == 3'h0 && go)
                left <= bus_req.kind inside {L1B_BUS_RIM, L1B_BUS_READ, L1B_BUS_WRITE, L1B_BUS_WKILL}
                    ? (bus_req.burst_n ? 3'h1 : 3'h4) : 3'h0;
            else if (left != 3'h0 && go)
                left <= left - 3'h1;
        end
    end
endmodule

// ===== tb_l1_cache_bus_ops.sv
`timescale 1ns/1ps
`include "l1b_params.svh"
// ********
// Testbench
// ********
module tb_l1_cache_bus_ops
    import l1b_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
    logic        core_ready, core_fwd, core_done, bus_grant, beat_valid, queues_busy, tlb_sync_in, array_wr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, a;
    logic [1:0]  beat_dw;
    logic [1:0]  dws [$];
    l1b_req_t    req;
    l1b_busreq_t bus_req, last;
    l1b_op_t     cops [4] = '{L1B_OP_DCBI, L1B_OP_DCBF, L1B_OP_DCBST, L1B_OP_ICBI};
    int          num_errors, checks, seed, nd, nf, ng;
    l1b_cache_ops u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_req(req),
        .core_ready(core_ready), .core_fwd(core_fwd), .core_done(core_done), .bus_grant(bus_grant),
        .beat_valid(beat_valid), .queues_busy(queues_busy), .tlb_sync_in(tlb_sync_in), .bus_req(bus_req),
        .beat_dw(beat_dw), .array_wr(array_wr), .fill_way());
    l1b_bus_model u_bus (.pclk(pclk), .presetn(presetn), .slow(slow), .bus_req(bus_req),
        .bus_grant(bus_grant), .beat_valid(beat_valid));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Record settled bus and fill activity
    always @(negedge pclk) begin
        if (bus_req.valid) last = bus_req;
        if (bus_grant) ng++;
        if (array_wr && beat_valid) dws.push_back(beat_dw);
        if (core_fwd) nf++;
        if (core_done) nd++;
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(logic w, logic [11:0] ad, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic op(l1b_op_t o, logic [31:0] ad, logic [3:0] at, l1b_coh_t c);
        int d0;
        d0 = nd;
        while (core_ready !== 1'b1) @(posedge pclk);
        req <= '{1'b1, o, ad, at, c != L1B_INV, 3'h2, c};
        @(posedge pclk);
        req.valid <= 1'b0;
        while (nd == d0) @(posedge pclk);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        $display("FAIL watchdog expected done seen hang");
        final_report;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, queues_busy, tlb_sync_in, slow} = '0;
        req = '0;
        seed = 54;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `L1B_OFF_CFG, 32'h0);
        chk("cfg reset", 32'h8, rd);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("test registers done");
        // Critical-first fills into one set, fast and slow bus
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            a = ($random(seed) & 32'hffff_f000) | (i << 3) | 32'h4;
            dws = {};
            op(L1B_OP_LOAD, a, 4'h2, L1B_INV);
            chk("fill kind", L1B_BUS_RIM, last.kind);
            chk("fill addr", a & ~32'h7, last.addr);
            chk("fill burst", 32'h0, last.burst_n);
            chk("fill beats", 32'h4, dws.size());
            chk("forwards", i + 1, nf);
            foreach (dws[j]) chk("beat order", (i + j) & 3, dws[j]);
        end
        apb(1'b1, `L1B_OFF_SET_SEL, 32'h0);
        apb(1'b0, `L1B_OFF_VALID, 32'h0);
        chk("ways used", 32'hf, rd);
        apb(1'b1, `L1B_OFF_CFG, 32'hb);
        apb(1'b0, `L1B_OFF_VALID, 32'h0);
        chk("flash clear", 32'h0, rd);
        apb(1'b1, `L1B_OFF_CFG, 32'hc);
        repeat (2) op(L1B_OP_LOAD, 32'h0, 4'h2, L1B_INV);
        apb(1'b0, `L1B_OFF_VALID, 32'h0);
        chk("assist", 32'h11, rd);
        $display("test fills done");
        op(L1B_OP_LOAD, 32'h0000_0104, 4'h4, L1B_INV);
        chk("inhibited kind", L1B_BUS_READ, last.kind);
        chk("inhibited single", 32'h1, last.burst_n);
        op(L1B_OP_STORE, 32'h0000_0108, 4'h8, L1B_INV);
        chk("write-through", {L1B_BUS_WRITE, 1'b1}, {last.kind, last.burst_n});
        // Cache control operations with broadcast enable off, then on
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, `L1B_OFF_CFG, {26'h0, k[2], 5'h08});
            a = ng;
            op(cops[k % 4], 32'h0000_0300, 4'h2, L1B_EXC);
            chk("broadcast", (k > 3 && k != 7), ng - a);
            apb(1'b0, `L1B_OFF_STATUS, 32'h0);
            if (k % 4 != 3) chk("to l2", 32'h1, {31'h0, rd[7]});
        end
        apb(1'b1, `L1B_OFF_CFG, 32'h8);
        a = ng;
        op(L1B_OP_DCBZ, 32'h0000_0400, 4'h2, L1B_EXC);
        chk("zero hit", L1B_BUS_KILL, last.kind);
        op(L1B_OP_DCBZ, 32'h0000_0420, 4'h2, L1B_INV);
        chk("zero miss", L1B_BUS_WKILL, last.kind);
        chk("zero broadcast", 32'h2, ng - a);
        op(L1B_OP_SNOOP, 32'h0000_0508, 4'h2, L1B_MOD);
        chk("push kind", L1B_BUS_WRITE, last.kind);
        chk("push addr", 32'h0000_0500, last.addr);
        $display("test control ops done");
        // Barriers stall on busy queues and on the sync input
        for (int k = 0; k < 2; k++) begin
            queues_busy <= (k == 0);
            tlb_sync_in <= (k == 1);
            a = nd;
            fork
                op(k ? L1B_OP_TLBSYNC : L1B_OP_SYNC, 32'h0, 4'h0, L1B_INV);
                begin
                    repeat (20) @(posedge pclk);
                    chk("held", a, nd);
                    queues_busy <= 1'b0;
                    tlb_sync_in <= 1'b0;
                end
            join
            chk("released", a + 1, nd);
        end
        $display("test barriers done");
        final_report;
    end
endmodule
